/* logic/hpf_top.sv */
// host side pin function block: host bus front end, dma pins, shared pin muxing
// assumes all pins synchronous to mclk; internal functions sit outside this block
`timescale 1ns/1ps
module hpf_top (
    // clock and resets
    input wire logic mclk,
    input wire logic nrst,
    input wire logic master_reset_in,
    // register port
    input wire logic [3:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    // host bus
    input wire logic [15:0] host_addr,
    input wire logic [7:0] host_data_in,
    output logic [7:0] host_data_out,
    output logic host_data_oe,
    input wire logic host_rd_n,
    input wire logic host_wr_n,
    input wire logic host_aen,
    output logic chan_rdy_out,
    output logic chan_rdy_oe,
    input wire logic epp_busy,
    output logic host_wr_strobe,
    output logic [7:0] host_wr_data,
    // dma
    output logic [3:0] dma_req,
    input wire logic [3:0] dma_ack_n,
    input wire logic term_count,
    output logic [3:0] dma_done,
    // shared pin sources from internal functions
    input wire logic irq14_src,
    input wire logic irq15_src,
    input wire logic gpio1_line4,
    input wire logic gpio1_line5,
    input wire logic gpio1_line6,
    input wire logic gpio1_line7,
    input wire logic power_led_out,
    input wire logic watchdog_out,
    input wire logic keyctl_port1_line4,
    input wire logic sci_src,
    // shared pins
    output logic pin_irq14,
    output logic pin_irq15,
    output logic pin_drq0,
    input wire logic pin_dack0_in,
    output logic gpio1_line6_in,
    output logic keyctl_port1_line5,
    output logic clk_is_48
);
    import hpf_pkg::*;

    hpf_sel_if sel();
    hpf_sel_decode u_dec (.sel(sel));

    logic rst;
    logic [7:0] host_pin_function_select;
    logic [7:0] global_option_reg;
    logic [3:0] req_soft;
    logic [15:0] host_base;
    logic [7:0] host_latch;
    logic rd_q;
    logic wr_q;
    logic [3:0] ack_seen;
    logic [3:0] next_req;
    logic next_drq0;
    logic host_hit;
    logic [3:0] ack_now;

    // high master reset joins the port reset
    assign rst = !nrst || master_reset_in;
    assign sel.pin_sel = host_pin_function_select;

    // register writes
    always_ff @(posedge mclk) begin
        if (rst) begin
            host_pin_function_select <= HPF_PIN_SEL_RST;
            global_option_reg <= HPF_GLOBAL_OPT_RST;
            host_base <= {HPF_ZERO8, HPF_ZERO8};
        end else if (reg_wr) begin
            unique case (reg_addr)
                HPF_IDX_PIN_SEL: host_pin_function_select <= reg_wdata;
                HPF_IDX_GLOBAL_OPT: global_option_reg <= reg_wdata;
                HPF_IDX_HOST_BASE_LO: host_base[7:0] <= reg_wdata;
                HPF_IDX_HOST_BASE_HI: host_base[15:8] <= reg_wdata;
                default: ;
            endcase
        end
    end

    // software dma requests; terminal count clears the acked channel
    always_ff @(posedge mclk) begin
        if (rst) begin
            req_soft <= 4'h0;
        end else begin
            req_soft <= next_req;
        end
    end

    // acked channels only count if currently requesting
    assign ack_now = ~dma_ack_n & req_soft;

    always_comb begin
        next_req = req_soft;
        if (reg_wr && reg_addr == HPF_IDX_DMA_REQ) begin
            next_req = reg_wdata[3:0];
        end
        if (term_count) begin
            next_req = next_req & ~ack_now;
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            dma_done <= 4'h0;
        end else begin
            dma_done <= term_count ? ack_now : 4'h0;
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            ack_seen <= 4'h0;
        end else if (reg_rd && reg_addr == HPF_IDX_STATUS) begin
            ack_seen <= ack_now;
        end else begin
            ack_seen <= ack_seen | ack_now;
        end
    end

    assign host_hit = (host_addr == host_base) && !host_aen;

    always_ff @(posedge mclk) begin
        if (rst) begin
            rd_q <= 1'b0;
            wr_q <= 1'b0;
        end else begin
            rd_q <= !host_rd_n && host_hit;
            wr_q <= !host_wr_n && host_hit;
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            host_latch <= HPF_ZERO8;
            host_wr_strobe <= 1'b0;
            host_wr_data <= HPF_ZERO8;
        end else begin
            host_wr_strobe <= !host_wr_n && host_hit && !wr_q;
            if (!host_wr_n && host_hit && !wr_q) begin
                host_latch <= host_data_in;
                host_wr_data <= host_data_in;
            end
        end
    end

    // drive data bus during hit read
    always_ff @(posedge mclk) begin
        if (rst) begin
            host_data_out <= HPF_ZERO8;
            host_data_oe <= 1'b0;
        end else begin
            host_data_oe <= !host_rd_n && host_hit;
            host_data_out <= host_latch;
        end
    end

    // open drain ready, low while epp busy in a cycle
    always_ff @(posedge mclk) begin
        if (rst) begin
            chan_rdy_out <= 1'b0;
            chan_rdy_oe <= 1'b0;
        end else begin
            chan_rdy_out <= 1'b0;
            chan_rdy_oe <= global_option_reg[HPF_OPT_EPP_BIT] && epp_busy
                && host_hit && (!host_rd_n || !host_wr_n);
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            clk_is_48 <= 1'b0;
        end else begin
            clk_is_48 <= global_option_reg[HPF_OPT_CLK48_BIT];
        end
    end

    always_comb begin
        unique case (sel.fn_drq0)
            HPF_FN_DEFAULT: next_drq0 = req_soft[0];
            HPF_FN_GPIO: next_drq0 = gpio1_line7 | power_led_out;
            HPF_FN_ALT: next_drq0 = keyctl_port1_line4;
            HPF_FN_EXTRA: next_drq0 = sci_src;
        endcase
    end

    // shared output pins, registered
    always_ff @(posedge mclk) begin
        if (rst) begin
            dma_req <= 4'h0;
            pin_drq0 <= 1'b0;
            pin_irq14 <= 1'b0;
            pin_irq15 <= 1'b0;
        end else begin
            dma_req <= {req_soft[3:1], 1'b0};
            pin_drq0 <= next_drq0;
            pin_irq14 <= (sel.fn_irq14 == HPF_FN_DEFAULT) ? irq14_src
                : (sel.fn_irq14 == HPF_FN_GPIO) ? gpio1_line4 : power_led_out;
            pin_irq15 <= (sel.fn_irq15 == HPF_FN_DEFAULT) ? irq15_src
                : (sel.fn_irq15 == HPF_FN_GPIO) ? gpio1_line5 : watchdog_out;
        end
    end

    // dack0 pin routed to its selected user
    always_ff @(posedge mclk) begin
        if (rst) begin
            gpio1_line6_in <= 1'b0;
            keyctl_port1_line5 <= 1'b0;
        end else begin
            gpio1_line6_in <= (sel.fn_dack0 == HPF_FN_GPIO) && pin_dack0_in;
            keyctl_port1_line5 <= (sel.fn_dack0 == HPF_FN_ALT) && pin_dack0_in;
        end
    end

    // register reads, data one cycle later
    always_ff @(posedge mclk) begin
        if (rst) begin
            reg_rdata <= HPF_ZERO8;
        end else if (reg_rd) begin
            unique case (reg_addr)
                HPF_IDX_PIN_SEL: reg_rdata <= host_pin_function_select;
                HPF_IDX_GLOBAL_OPT: reg_rdata <= global_option_reg;
                HPF_IDX_DMA_REQ: reg_rdata <= {4'h0, req_soft};
                HPF_IDX_STATUS: reg_rdata <= {ack_seen, ~dma_ack_n};
                HPF_IDX_HOST_BASE_LO: reg_rdata <= host_base[7:0];
                HPF_IDX_HOST_BASE_HI: reg_rdata <= host_base[15:8];
                HPF_IDX_HOST_DATA: reg_rdata <= host_latch;
                default: reg_rdata <= HPF_ZERO8;
            endcase
        end else begin
            reg_rdata <= HPF_ZERO8;
        end
    end

    chk_irq14_reserved: assert property (@(posedge mclk) disable iff (rst)
        !rst && host_pin_function_select[HPF_F_IRQ14_LSB +: 2] == 2'b11
        |=> pin_irq14 == $past(irq14_src))
        else $error("irq14 reserved code not default");
    chk_irq15_reserved: assert property (@(posedge mclk) disable iff (rst)
        !rst && host_pin_function_select[HPF_F_IRQ15_LSB +: 2] == 2'b11
        |=> pin_irq15 == $past(irq15_src))
        else $error("irq15 reserved code not default");
    chk_irq14_led: assert property (@(posedge mclk) disable iff (rst)
        !rst && host_pin_function_select[HPF_F_IRQ14_LSB +: 2] == 2'b10
        |=> pin_irq14 == $past(power_led_out))
        else $error("irq14 led route wrong");
    chk_irq15_wdt: assert property (@(posedge mclk) disable iff (rst)
        !rst && host_pin_function_select[HPF_F_IRQ15_LSB +: 2] == 2'b10
        |=> pin_irq15 == $past(watchdog_out))
        else $error("irq15 watchdog route wrong");
    chk_aen_blocks: assert property (@(posedge mclk) disable iff (rst)
        host_aen |=> !host_data_oe && !host_wr_strobe)
        else $error("host cycle taken during aen");

    // tc seen on acked channel 1, then its request falls in two steps
    sequence seq_tc_on_ch1;
        term_count && ack_now[1] && !reg_wr;
    endsequence
    sequence seq_ch1_drops;
        !req_soft[1] ##1 !dma_req[1];
    endsequence
    chk_tc_ends: assert property (@(posedge mclk) disable iff (rst)
        seq_tc_on_ch1 |=> seq_ch1_drops)
        else $error("tc did not end channel");
    chk_mreset_clear: assert property (@(posedge mclk)
        master_reset_in |=> host_pin_function_select == HPF_PIN_SEL_RST)
        else $error("master reset ignored");
    chk_mreset_pins: assert property (@(posedge mclk)
        master_reset_in |=> dma_req == 4'h0 && dma_done == 4'h0 && !host_data_oe
            && !chan_rdy_oe && !host_wr_strobe)
        else $error("master reset left an output set");
    // rate bit follows option; no check across a reset edge
    chk_rate_bit: assert property (@(posedge mclk) disable iff (rst)
        !rst |=> clk_is_48 == $past(global_option_reg[HPF_OPT_CLK48_BIT]))
        else $error("rate select mismatch");
    // ready held low in epp busy
    chk_epp_stretch: assert property (@(posedge mclk) disable iff (rst)
        global_option_reg[HPF_OPT_EPP_BIT] && epp_busy && host_hit && !host_rd_n
        |=> chan_rdy_oe)
        else $error("epp cycle not stretched");
    chk_rdy_release: assert property (@(posedge mclk) disable iff (rst)
        !global_option_reg[HPF_OPT_EPP_BIT] |=> !chan_rdy_oe)
        else $error("ready pulled outside epp mode");
    chk_drq0_sci: assert property (@(posedge mclk) disable iff (rst)
        !rst && host_pin_function_select[HPF_F_DRQ0_LSB +: 2] == 2'b11
        |=> pin_drq0 == $past(sci_src))
        else $error("drq0 sci route wrong");
    // default code routes channel 0 request
    chk_drq0_default: assert property (@(posedge mclk) disable iff (rst)
        !rst && host_pin_function_select[HPF_F_DRQ0_LSB +: 2] == 2'b00
        |=> pin_drq0 == $past(req_soft[0]))
        else $error("drq0 default route wrong");
    // gpio code passes the dack0 pin to gpio only
    chk_dack0_gpio: assert property (@(posedge mclk) disable iff (rst)
        !rst && host_pin_function_select[HPF_F_DACK0_LSB +: 2] == 2'b01
        |=> gpio1_line6_in == $past(pin_dack0_in) && !keyctl_port1_line5)
        else $error("dack0 gpio route wrong");
    // default and reserved codes feed neither user
    chk_dack0_idle: assert property (@(posedge mclk) disable iff (rst)
        host_pin_function_select[HPF_F_DACK0_LSB +: 2] inside {2'b00, 2'b11}
        |=> !gpio1_line6_in && !keyctl_port1_line5)
        else $error("dack0 pin leaked to a user");

    // first hit write edge; the strobe and byte follow one cycle later
    sequence seq_first_write;
        !host_wr_n && host_hit && !wr_q;
    endsequence
    sequence seq_strobe_out;
        host_wr_strobe && host_wr_data == $past(host_data_in);
    endsequence
    // write strobe carries the sampled byte
    chk_wr_strobe: assert property (@(posedge mclk) disable iff (rst)
        seq_first_write |=> seq_strobe_out)
        else $error("host write strobe or byte wrong");
    chk_strobe_single: assert property (@(posedge mclk) disable iff (rst)
        host_wr_strobe |=> !host_wr_strobe)
        else $error("host write strobe repeated");
    chk_wr_latch: assert property (@(posedge mclk) disable iff (rst)
        host_wr_strobe |-> host_latch == $past(host_data_in))
        else $error("host write data not latched");
endmodule

/* logic/hpf_pkg.sv */
// package for the host pin function block: register indices, fields, reset values
// assumes a single 10 MHz clock domain and a plain strobe register port
package hpf_pkg;
    // register indices on the internal port
    localparam logic [3:0] HPF_IDX_PIN_SEL = 4'h0;
    localparam logic [3:0] HPF_IDX_GLOBAL_OPT = 4'h1;
    localparam logic [3:0] HPF_IDX_DMA_REQ = 4'h2;
    localparam logic [3:0] HPF_IDX_STATUS = 4'h3;
    localparam logic [3:0] HPF_IDX_HOST_BASE_LO = 4'h4;
    localparam logic [3:0] HPF_IDX_HOST_BASE_HI = 4'h5;
    localparam logic [3:0] HPF_IDX_HOST_DATA = 4'h6;
    // field positions in the pin select and global option registers
    localparam int HPF_F_IRQ14_LSB = 0;
    localparam int HPF_F_IRQ15_LSB = 2;
    localparam int HPF_F_DACK0_LSB = 4;
    localparam int HPF_F_DRQ0_LSB = 6;
    localparam int HPF_OPT_CLK48_BIT = 5;
    localparam int HPF_OPT_EPP_BIT = 0;
    // reset values
    localparam logic [7:0] HPF_PIN_SEL_RST = 8'h00;
    localparam logic [7:0] HPF_GLOBAL_OPT_RST = 8'h00;
    localparam logic [7:0] HPF_ZERO8 = 8'h00;
    // reference clock figures in MHz
    localparam int HPF_REF_LOW_MHZ = 24;
    localparam int HPF_REF_HIGH_MHZ = 48;
    // pin function codes
    typedef enum logic [1:0] {
        HPF_FN_DEFAULT = 2'b00,
        HPF_FN_GPIO = 2'b01,
        HPF_FN_ALT = 2'b10,
        HPF_FN_EXTRA = 2'b11
    } hpf_fn_t;
endpackage

/* logic/hpf_sel_if.sv */
// interface carrying decoded pin function selects between top and decoder
// assumes one clock domain; the decoder is purely combinational
`timescale 1ns/1ps
interface hpf_sel_if;
    logic [7:0] pin_sel;
    hpf_pkg::hpf_fn_t fn_dack0;
    hpf_pkg::hpf_fn_t fn_drq0;
    hpf_pkg::hpf_fn_t fn_irq14;
    hpf_pkg::hpf_fn_t fn_irq15;
    modport ctrl (output pin_sel, input fn_dack0, fn_drq0, fn_irq14, fn_irq15);
    modport dec (input pin_sel, output fn_dack0, fn_drq0, fn_irq14, fn_irq15);
endinterface

/* logic/hpf_sel_decode.sv */
// decoder from the pin select register to per-pin function codes
// assumes the register value comes from the top module through the interface
`timescale 1ns/1ps
module hpf_sel_decode (
    // select fields in, functions out
    hpf_sel_if.dec sel
);
    import hpf_pkg::*;

    // reserved code folds back to default
    function automatic hpf_fn_t fold3(input logic [1:0] code);
        fold3 = (code == 2'b11) ? HPF_FN_DEFAULT : hpf_fn_t'(code);
    endfunction

    assign sel.fn_dack0 = fold3(sel.pin_sel[HPF_F_DACK0_LSB +: 2]);
    assign sel.fn_drq0 = hpf_fn_t'(sel.pin_sel[HPF_F_DRQ0_LSB +: 2]);
    assign sel.fn_irq14 = fold3(sel.pin_sel[HPF_F_IRQ14_LSB +: 2]);
    assign sel.fn_irq15 = fold3(sel.pin_sel[HPF_F_IRQ15_LSB +: 2]);
endmodule

/* testbench/hpf_dma_host.sv */
// far-side model: host dma controller serving one requesting channel at a time
// assumes requests are synchronous to mclk; acknowledges are active low
`timescale 1ns/1ps
module hpf_dma_host (
    // clock and reset
    input wire logic mclk,
    input wire logic nrst,
    // dma pins
    input wire logic [3:0] req,
    output logic [3:0] ack_n,
    output logic tc
);
    int ch;
    // grant loop with a random stall before each grant
    initial begin
        ack_n = 4'hf;
        tc = 1'b0;
        forever begin
            @(posedge mclk);
            if (nrst && req != 4'h0) begin
                ch = req[0] ? 0 : req[1] ? 1 : req[2] ? 2 : 3;
                repeat ($urandom_range(3)) @(posedge mclk);
                ack_n[ch] <= 1'b0;
                @(posedge mclk);
                tc <= 1'b1;
                @(posedge mclk);
                tc <= 1'b0;
                ack_n <= 4'hf;
                repeat (3) @(posedge mclk); // let the request drop first
            end
        end
    end
endmodule

/* testbench/hpf_top_test.sv */
// self-checking bench for hpf_top with the dma host model on its far side
// assumes the package, design files and hpf_dma_host are compiled first
`timescale 1ns/1ps
`define CMP(n, e, g) begin n_checks++; if ((g) !== (e)) begin miscompares++; \
    $display("unexpected %s expected %h seen %h", n, e, g); end end
module hpf_top_test;
    import hpf_pkg::*;
    typedef struct {string nm; int sel; logic [7:0] e;} hpf_note_t;
    hpf_note_t notes[$];
    hpf_note_t nt;
    int miscompares = 0, n_checks = 0;
    logic mclk = 1'b0, nrst = 1'b0, master_reset_in = 1'b0;
    logic [3:0] reg_addr = 4'h0;
    logic [7:0] reg_wdata = 8'h00;
    logic reg_wr = 1'b0, reg_rd = 1'b0, host_rd_n = 1'b1, host_wr_n = 1'b1, host_aen = 1'b0;
    logic [15:0] host_addr = 16'h0000;
    logic [7:0] host_data_in = 8'h00;
    logic [9:0] src = 10'h000;
    logic epp_busy = 1'b0, dack_en = 1'b0, dack_rnd = 1'b0, drq0_en = 1'b0;
    logic rd_q = 1'b0, probe = 1'b0;
    logic [3:0] done_acc = 4'h0;
    logic [7:0] reg_rdata, host_data_out, host_wr_data, hd;
    logic host_data_oe, chan_rdy_out, chan_rdy_oe, host_wr_strobe, term_count;
    logic [3:0] dma_req, dma_done, ack_n;
    logic pin_irq14, pin_irq15, pin_drq0, gpio1_line6_in, keyctl_port1_line5, clk_is_48;
    logic [15:0] base;
    logic [31:0] v;
    logic [1:0] c;
    logic i14, i15, d0;

    hpf_top hpf_top_inst (
        .mclk, .nrst, .master_reset_in, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
        .host_addr, .host_data_in, .host_data_out, .host_data_oe, .host_rd_n, .host_wr_n,
        .host_aen, .chan_rdy_out, .chan_rdy_oe, .epp_busy, .host_wr_strobe, .host_wr_data,
        .dma_req, .dma_ack_n(ack_n), .term_count, .dma_done,
        .irq14_src(src[0]), .irq15_src(src[1]), .gpio1_line4(src[2]), .gpio1_line5(src[3]),
        .gpio1_line6(src[4]), .gpio1_line7(src[5]), .power_led_out(src[6]),
        .watchdog_out(src[7]), .keyctl_port1_line4(src[8]), .sci_src(src[9]),
        .pin_irq14, .pin_irq15, .pin_drq0, .pin_dack0_in(dack_en ? dack_rnd : ack_n[0]),
        .gpio1_line6_in, .keyctl_port1_line5, .clk_is_48
    );
    hpf_dma_host hpf_dma_host_inst (
        .mclk, .nrst, .req({dma_req[3:1], pin_drq0 & drq0_en}), .ack_n, .tc(term_count)
    );

    // 10 MHz clock
    always #50 mclk = ~mclk;

    // output selector for the scoreboard
    function automatic logic [7:0] obs(input int s);
        case (s)
            0: return reg_rdata;
            1: return {pin_irq14, pin_irq15, pin_drq0, chan_rdy_out, chan_rdy_oe,
                       host_data_oe, host_wr_strobe, clk_is_48};
            2: return {7'h00, gpio1_line6_in};
            3: return {7'h00, keyctl_port1_line5};
            4: return {done_acc, dma_req};
            6: return host_data_out;
            default: return host_wr_data;
        endcase
    endfunction

    task automatic note(input string nm, input int s, input logic [7:0] e);
        notes.push_back('{nm, s, e});
    endtask

    // one probe cycle; pins are settled by then
    task automatic look();
        @(posedge mclk) probe <= 1'b1;
        @(posedge mclk) probe <= 1'b0;
    endtask

    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge mclk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge mclk) reg_wr <= 1'b0;
    endtask

    task automatic rd(input logic [3:0] a, input logic [7:0] e);
        @(posedge mclk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        note("reg read", 0, e);
        @(posedge mclk) reg_rd <= 1'b0;
    endtask

    // refused cycles carry inverted data so a wrong latch shows
    task automatic host(input logic [15:0] a, input logic aen, input logic w,
                        input logic [7:0] e);
        @(posedge mclk);
        host_addr <= a;
        host_aen <= aen;
        host_data_in <= e[1] ? hd : ~hd;
        // separate strobes, one low per cycle
        host_wr_n <= !w;
        host_rd_n <= w;
        note("host pins", 1, e);
        if (e[1]) note("host data", 5, hd);
        if (!w && e[2]) note("host out", 6, hd);
        look();
        host_wr_n <= 1'b1;
        host_rd_n <= 1'b1;
    endtask

    task automatic end_of_test();
        $display("checks %0d miscompares %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask

    // reads in flight and dma completions seen
    always @(posedge mclk) begin
        rd_q <= reg_rd;
        done_acc <= nrst ? (done_acc | dma_done) : 4'h0;
    end

    // scoreboard: oldest note against the outputs now
    always @(negedge mclk) begin
        while ((rd_q || probe) && notes.size() > 0) begin
            nt = notes.pop_front();
            `CMP(nt.nm, nt.e, obs(nt.sel))
            if (rd_q) break;
        end
    end

    // run takes about 200 cycles; cut off well past that
    initial begin
        #1000000;
        miscompares++;
        end_of_test();
    end

    initial begin
        void'($urandom(54157));
        repeat (10) @(posedge mclk);
        nrst <= 1'b1;
        rd(HPF_IDX_PIN_SEL, HPF_PIN_SEL_RST);
        wr(4'hf, 8'h5a);
        rd(4'hf, 8'h00);
        wr(HPF_IDX_GLOBAL_OPT, 8'h20);
        note("pins", 1, 8'h01);
        look();
        rd(HPF_IDX_GLOBAL_OPT, 8'h20);
        wr(HPF_IDX_GLOBAL_OPT, 8'h00);
        // all four channels at once, host serves one by one
        drq0_en <= 1'b1;
        wr(HPF_IDX_DMA_REQ, 8'h0f);
        @(posedge mclk);
        note("dma", 4, 8'h0e);
        note("pins", 1, 8'h20);
        look();
        repeat (300) if (done_acc !== 4'hf) @(posedge mclk);
        repeat (4) @(posedge mclk);
        note("dma", 4, 8'hf0);
        look();
        rd(HPF_IDX_STATUS, 8'hf0);
        rd(HPF_IDX_STATUS, 8'h00);
        drq0_en <= 1'b0;
        // host cycles: hit, near misses, dma cycles
        base = 16'($urandom);
        hd = 8'($urandom);
        wr(HPF_IDX_HOST_BASE_LO, base[7:0]);
        wr(HPF_IDX_HOST_BASE_HI, base[15:8]);
        host(base, 1'b0, 1'b1, 8'h02);
        host(base ^ 16'h8000, 1'b0, 1'b1, 8'h00);
        host(base ^ 16'h0001, 1'b0, 1'b1, 8'h00);
        host(base, 1'b1, 1'b1, 8'h00);
        host(base, 1'b0, 1'b0, 8'h04);
        host(base, 1'b1, 1'b0, 8'h00);
        rd(HPF_IDX_HOST_DATA, hd);
        wr(HPF_IDX_GLOBAL_OPT, 8'h01);
        epp_busy <= 1'b1;
        host(base, 1'b0, 1'b0, 8'h0c);
        wr(HPF_IDX_GLOBAL_OPT, 8'h00);
        host(base, 1'b0, 1'b0, 8'h04);
        epp_busy <= 1'b0;
        // every code of every field with random sources
        for (int k = 0; k < 4; k++) begin
            c = k[1:0];
            wr(HPF_IDX_PIN_SEL, {c, c, c, c});
            rd(HPF_IDX_PIN_SEL, {c, c, c, c});
            repeat (4) begin
                v = $urandom;
                @(posedge mclk);
                src <= v[9:0];
                dack_rnd <= v[10];
                dack_en <= c[0] ^ c[1];
                i14 = (c == 2'b01) ? v[2] : (c == 2'b10) ? v[6] : v[0];
                i15 = (c == 2'b01) ? v[3] : (c == 2'b10) ? v[7] : v[1];
                d0 = (c == 2'b01) ? v[5] | v[6] : (c == 2'b10) ? v[8] : c[0] & v[9];
                note("pins", 1, {i14, i15, d0, 5'h00});
                note("gpio1 line6", 2, {7'h00, v[10] & (c == 2'b01)});
                note("keyctl line5", 3, {7'h00, v[10] & (c == 2'b10)});
                look();
            end
        end
        // master reset wipes both registers
        src <= 10'h000;
        dack_en <= 1'b0;
        wr(HPF_IDX_PIN_SEL, 8'h55);
        wr(HPF_IDX_GLOBAL_OPT, 8'h20);
        @(posedge mclk) master_reset_in <= 1'b1;
        @(posedge mclk) master_reset_in <= 1'b0;
        note("pins", 1, 8'h00);
        look();
        rd(HPF_IDX_PIN_SEL, 8'h00);
        rd(HPF_IDX_GLOBAL_OPT, 8'h00);
        end_of_test();
    end
endmodule
